// ===== rtl/buck_seq_pkg.sv
/*
 * Constants and carrier types for the buck startup and fault sequencer.
 * Assumes a single 40 MHz system clock and an APB completer with 32-bit data.
 */
package buck_seq_pkg;
	// clock
	localparam int CLK_KHZ = 40000;
	localparam int CLK_NS = 25;

	// apb register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] SSREF_OFS = 8'h08;
	localparam logic [7:0] PERIOD_OFS = 8'h0c;
	localparam logic [31:0] CTRL_RST = 32'h0000_0001;

	// pre-bias duty steps
	localparam logic [3:0] PB_STEPS = 4'h8;
	localparam logic [4:0] PB_PULSES = 5'h10;
	localparam int PB_FRAC_SHIFT = 3;

	// soft-start reference, kept in microvolts
	localparam int SS_SLOPE_UV_PER_US_X10 = 4;
	localparam int SS_STEP_UV_PER_CLK = SS_SLOPE_UV_PER_US_X10 * CLK_NS / 10;
	localparam logic [20:0] SS_FINAL_UV = 21'd1500000;
	localparam int TSTART_US = 1500;
	localparam int TSTART_CYCLES = TSTART_US * (CLK_KHZ / 1000);
	localparam int HICCUP_US = 20480;
	localparam int HICCUP_CYCLES = HICCUP_US * (CLK_KHZ / 1000);

	// current sampling times
	localparam int SAMPLE_DELAY_NS = 40;
	localparam int SAMPLE_DELAY_CYCLES = (SAMPLE_DELAY_NS + CLK_NS - 1) / CLK_NS;
	localparam int SAMPLE_WIDTH_NS = 30;
	localparam int SAMPLE_WIDTH_CYCLES = (SAMPLE_WIDTH_NS / CLK_NS) < 1 ? 1 : SAMPLE_WIDTH_NS / CLK_NS;

	// oscillator
	localparam int FREQ_TABLE_N = 13;
	localparam logic [7:0] PERIOD_MIN = 8'd26;
	localparam logic [7:0] PERIOD_MAX = 8'd133;
	localparam logic [8:0] SYNC_LOST_CYCLES = 9'd300;

	typedef enum logic [1:0] {
		STRAP_FLOAT = 2'b00,
		STRAP_VCC = 2'b01,
		STRAP_POWER_GROUND = 2'b10
	} strap_type;

	typedef enum logic [1:0] {
		ST_OFF = 2'b00,
		ST_SOFT = 2'b01,
		ST_RUN = 2'b10,
		ST_HICCUP = 2'b11
	} seq_state_type;

	typedef struct packed {
		logic en_ok;
		logic vcc_ok;
		logic thermal_trip;
		logic overvoltage_protection;
	} supervise_type;

	typedef struct packed {
		logic hs_on;
		logic ls_on;
	} gate_type;
endpackage

// ===== rtl/buck_startup_fault_sequencer.sv
/*
 * Sequencing logic of a synchronous buck: pre-bias startup, digital soft-start,
 * valley current sampling with hiccup, shutdown, thermal restart and smooth sync.
 * Assumes analog comparators and the pwm demand are synchronous to clk_i.
 */
// Local design decisions: the APB interface to the registers and the register addresses.
// Notes on behaviour
// - pre-biased start: low side off until first high-side pulse.
// - low side starts at one-eighth period, rises in one-eighth steps.
// - each duty step lasts sixteen pulses, eight steps in all.
// - soft-start begins only when enable and bias supply are both good.
// - reference ramps from zero at 0.4 mV/us up to 1.5 V.
// - output startup time is a fixed 1.5 ms.
// - overcurrent and overvoltage protection stay active during the ramp.
// - enable below its off threshold shuts down both drivers.
// - overcurrent limit picked from three strap states of the select pin.
// - sample current 30 ns, one-eighth period before the valley.
// - short low-side on-time: sample 40 ns after falling slope starts.
// - flag overcurrent when sampled current exceeds selected limit.
// - on overcurrent latch flag, hold reference at zero 20.48 ms.
// - after hiccup clear flag, restart soft-start, repeat while overloaded.
// - thermal trip turns off both switches and resets soft-start.
// - restart with fresh soft-start once temperature is back in band.
// - switching frequency 300 to 1500 kHz from a resistor table.
// - external clock in steady state: move gradually to its frequency.
// - external clock removed: move gradually back to free-running.
`timescale 1ns/1ps
module buck_startup_fault_sequencer #(
	parameter int START_CYCLES = buck_seq_pkg::TSTART_CYCLES,
	parameter int HICCUP_LEN = buck_seq_pkg::HICCUP_CYCLES,
	parameter int CUR_W = 8,
	parameter logic [7:0] LIMIT_FLOAT = 8'hc0,
	parameter logic [7:0] LIMIT_VCC = 8'he0,
	parameter logic [7:0] LIMIT_POWER_GROUND = 8'h90
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// apb completer
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic pready_o,
	output logic [31:0] prdata_o,
	output logic pslverr_o,
	// analog supervision and straps
	input wire buck_seq_pkg::supervise_type sup_i,
	input wire buck_seq_pkg::strap_type current_limit_select_pin_i,
	input wire logic [3:0] freq_sel_i,
	input wire logic freq_set_and_sync_pin_i,
	// power stage
	input wire logic pwm_demand_i,
	input wire logic [CUR_W-1:0] ls_current_i,
	output buck_seq_pkg::gate_type gate_o,
	output logic [20:0] ss_ref_uv_o,
	output logic overcurrent_flag_o,
	output logic startup_done_o
);
	import buck_seq_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// functions

	function automatic logic [7:0] table_period(input logic [3:0] idx);
		logic [7:0] p;
		p = PERIOD_MAX;
		unique case (idx)
			4'd0: p = 8'd133;
			4'd1: p = 8'd100;
			4'd2: p = 8'd80;
			4'd3: p = 8'd67;
			4'd4: p = 8'd57;
			4'd5: p = 8'd50;
			4'd6: p = 8'd44;
			4'd7: p = 8'd40;
			4'd8: p = 8'd36;
			4'd9: p = 8'd33;
			4'd10: p = 8'd31;
			4'd11: p = 8'd29;
			4'd12: p = 8'd26;
			default: p = PERIOD_MAX;
		endcase
		return p;
	endfunction

	function automatic logic [7:0] clamp_period(input logic [8:0] p);
		if (p < {1'b0, PERIOD_MIN}) begin
			return PERIOD_MIN;
		end else if (p > {1'b0, PERIOD_MAX}) begin
			return PERIOD_MAX;
		end
		return p[7:0];
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// supervision and straps

	logic por;
	logic shut;
	logic strap_taken_ff;
	logic [CUR_W-1:0] limit_ff;
	logic [31:0] ctrl_ff;

	assign por = sup_i.en_ok && sup_i.vcc_ok && ctrl_ff[0];
	assign shut = !por || sup_i.thermal_trip;

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			strap_taken_ff <= 1'b0;
			limit_ff <= '0;
		end else if (!strap_taken_ff) begin
			strap_taken_ff <= 1'b1;
			unique case (current_limit_select_pin_i)
				STRAP_VCC: limit_ff <= LIMIT_VCC[CUR_W-1:0];
				STRAP_POWER_GROUND: limit_ff <= LIMIT_POWER_GROUND[CUR_W-1:0];
				default: limit_ff <= LIMIT_FLOAT[CUR_W-1:0];
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// switching oscillator and external sync

	logic sync_d_ff;
	logic sync_lock_ff;
	logic [8:0] sync_cnt_ff;
	logic [7:0] sync_per_ff;
	logic [7:0] period_ff;
	logic [7:0] phase_ff;
	logic sw_tick;
	logic [7:0] target;

	assign sw_tick = (phase_ff >= period_ff - 8'd1);
	assign target = sync_lock_ff ? sync_per_ff : table_period(freq_sel_i);

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			sync_d_ff <= 1'b0;
			sync_lock_ff <= 1'b0;
			sync_cnt_ff <= '0;
			sync_per_ff <= PERIOD_MAX;
		end else begin
			sync_d_ff <= freq_set_and_sync_pin_i;
			if (freq_set_and_sync_pin_i && !sync_d_ff) begin
				sync_cnt_ff <= 9'd1;
				sync_per_ff <= clamp_period(sync_cnt_ff);
				sync_lock_ff <= (sync_cnt_ff != 9'd0);
			end else if (sync_cnt_ff >= SYNC_LOST_CYCLES) begin
				sync_lock_ff <= 1'b0;
				sync_cnt_ff <= '0;
			end else if (sync_cnt_ff != 9'd0) begin
				sync_cnt_ff <= sync_cnt_ff + 9'd1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			phase_ff <= '0;
			// start at the strap frequency, no slew out of reset
			period_ff <= table_period(freq_sel_i);
		end else if (sw_tick) begin
			phase_ff <= '0;
			// one clock of period change per switching cycle
			if (period_ff < target) begin
				period_ff <= period_ff + 8'd1;
			end else if (period_ff > target) begin
				period_ff <= period_ff - 8'd1;
			end
		end else begin
			phase_ff <= phase_ff + 8'd1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sequence state, soft-start ramp and hiccup

	seq_state_type state_ff;
	logic [20:0] ss_ref_ff;
	logic [31:0] start_cnt_ff;
	logic [31:0] hic_cnt_ff;
	logic oc_event;
	logic ovp_hit;
	logic [20:0] ss_inc;

	assign ss_inc = 21'(SS_STEP_UV_PER_CLK) * {13'd0, period_ff};
	assign ovp_hit = sup_i.overvoltage_protection && (state_ff == ST_SOFT || state_ff == ST_RUN);

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			state_ff <= ST_OFF;
			hic_cnt_ff <= '0;
		end else if (shut) begin
			state_ff <= ST_OFF;
			hic_cnt_ff <= '0;
		end else begin
			unique case (state_ff)
				ST_OFF: state_ff <= ST_SOFT;
				ST_SOFT: begin
					if (oc_event) begin
						state_ff <= ST_HICCUP;
					end else if (ss_ref_ff == SS_FINAL_UV) begin
						state_ff <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (oc_event) begin
						state_ff <= ST_HICCUP;
					end
				end
				ST_HICCUP: begin
					if (hic_cnt_ff >= 32'(HICCUP_LEN - 1)) begin
						hic_cnt_ff <= '0;
						state_ff <= ST_SOFT;
					end else begin
						hic_cnt_ff <= hic_cnt_ff + 32'd1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i || shut || state_ff == ST_OFF || state_ff == ST_HICCUP) begin
			ss_ref_ff <= '0;
		end else if (state_ff == ST_SOFT && sw_tick) begin
			if (ss_ref_ff + ss_inc >= SS_FINAL_UV) begin
				ss_ref_ff <= SS_FINAL_UV;
			end else begin
				ss_ref_ff <= ss_ref_ff + ss_inc;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i || shut || state_ff == ST_OFF || state_ff == ST_HICCUP) begin
			start_cnt_ff <= '0;
			startup_done_o <= 1'b0;
		end else if (start_cnt_ff >= 32'(START_CYCLES - 1)) begin
			startup_done_o <= 1'b1;
		end else begin
			start_cnt_ff <= start_cnt_ff + 32'd1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pre-bias stepping of the low side

	logic hs_d_ff;
	logic first_hs_ff;
	logic pb_done_ff;
	logic [3:0] pb_step_ff;
	logic [4:0] pb_pulse_ff;
	logic [7:0] ls_cnt_ff;
	logic [11:0] ls_limit;
	logic hs_rise;
	logic hs_fall;
	logic active;

	assign active = (state_ff == ST_SOFT || state_ff == ST_RUN) && !ovp_hit;
	assign hs_rise = pwm_demand_i && !hs_d_ff;
	assign hs_fall = !pwm_demand_i && hs_d_ff;
	assign ls_limit = ({4'd0, period_ff} * {8'd0, pb_step_ff}) >> PB_FRAC_SHIFT;

	always_ff @(posedge clk_i) begin
		if (!rst_b_i || !active) begin
			hs_d_ff <= 1'b0;
			first_hs_ff <= 1'b0;
			pb_done_ff <= 1'b0;
			pb_step_ff <= 4'd1;
			pb_pulse_ff <= '0;
		end else begin
			hs_d_ff <= pwm_demand_i;
			if (hs_rise) begin
				first_hs_ff <= 1'b1;
			end
			if (hs_rise && first_hs_ff && !pb_done_ff) begin
				if (pb_pulse_ff == PB_PULSES - 5'd1) begin
					pb_pulse_ff <= '0;
					if (pb_step_ff == PB_STEPS) begin
						pb_done_ff <= 1'b1;
					end else begin
						pb_step_ff <= pb_step_ff + 4'd1;
					end
				end else begin
					pb_pulse_ff <= pb_pulse_ff + 5'd1;
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i || pwm_demand_i) begin
			ls_cnt_ff <= '0;
		end else if (ls_cnt_ff != 8'hff) begin
			ls_cnt_ff <= ls_cnt_ff + 8'd1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i || !active) begin
			gate_o <= '0;
		end else begin
			gate_o.hs_on <= pwm_demand_i;
			if (!first_hs_ff) begin
				gate_o.ls_on <= 1'b0;
			end else if (!pb_done_ff) begin
				gate_o.ls_on <= !pwm_demand_i && ({4'd0, ls_cnt_ff} < ls_limit);
			end else begin
				gate_o.ls_on <= !pwm_demand_i;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// valley current sampling and overcurrent flag

	logic [7:0] samp_at_ff;
	logic samp_arm_ff;
	logic [1:0] samp_w_ff;
	logic samp_hit;
	logic [7:0] eighth;
	logic [7:0] remain;

	assign eighth = period_ff >> PB_FRAC_SHIFT;
	assign remain = period_ff - phase_ff;
	assign samp_hit = samp_arm_ff && (phase_ff == samp_at_ff);
	assign oc_event = samp_w_ff != 2'd0 && ls_current_i > limit_ff;

	always_ff @(posedge clk_i) begin
		if (!rst_b_i || !active) begin
			samp_arm_ff <= 1'b0;
			samp_at_ff <= '0;
			samp_w_ff <= '0;
		end else begin
			if (hs_fall) begin
				samp_arm_ff <= 1'b1;
				if (remain >= eighth) begin
					samp_at_ff <= period_ff - eighth;
				end else begin
					samp_at_ff <= phase_ff + 8'(SAMPLE_DELAY_CYCLES);
				end
			end else if (samp_hit) begin
				samp_arm_ff <= 1'b0;
			end
			if (samp_hit) begin
				samp_w_ff <= 2'(SAMPLE_WIDTH_CYCLES);
			end else if (samp_w_ff != 2'd0) begin
				samp_w_ff <= samp_w_ff - 2'd1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i || shut) begin
			overcurrent_flag_o <= 1'b0;
		end else if (oc_event) begin
			overcurrent_flag_o <= 1'b1;
		end else if (state_ff == ST_HICCUP && hic_cnt_ff >= 32'(HICCUP_LEN - 1)) begin
			overcurrent_flag_o <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			ss_ref_uv_o <= '0;
		end else begin
			ss_ref_uv_o <= ss_ref_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// apb completer: one wait state, errors on unmapped offsets

	logic acc;
	logic mapped;

	assign acc = psel_i && penable_i && !pready_o;
	assign mapped = paddr_i == CTRL_OFS || paddr_i == STATUS_OFS ||
		paddr_i == SSREF_OFS || paddr_i == PERIOD_OFS;

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			ctrl_ff <= CTRL_RST;
		end else if (acc && pwrite_i && paddr_i == CTRL_OFS) begin
			ctrl_ff <= {31'd0, pwdata_i[0]};
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= '0;
		end else begin
			pready_o <= acc;
			pslverr_o <= acc && !mapped;
			prdata_o <= '0;
			if (acc && !pwrite_i) begin
				unique case (paddr_i)
					CTRL_OFS: prdata_o <= ctrl_ff;
					STATUS_OFS: prdata_o <= {24'd0, sync_lock_ff, pb_done_ff,
						sup_i.thermal_trip, startup_done_o, overcurrent_flag_o,
						1'b0, state_ff};
					SSREF_OFS: prdata_o <= {11'd0, ss_ref_ff};
					PERIOD_OFS: prdata_o <= {16'd0, target, period_ff};
					default: prdata_o <= '0;
				endcase
			end
		end
	end
endmodule // buck_startup_fault_sequencer

// ===== tb/power_stage_model.sv
/* power stage model: analog pwm demand and low-side current sense
   assumes gate commands are active high and synchronous to clk_i */
`timescale 1ns/1ps
module power_stage_model (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// bench controls
	input wire logic [7:0] per_i,
	input wire logic [7:0] high_i,
	input wire logic [7:0] cur_lvl_i,
	// power stage
	input wire buck_seq_pkg::gate_type gate_i,
	output logic pwm_demand_o,
	output logic [7:0] ls_current_o
);
	import buck_seq_pkg::*;
	logic [7:0] phase_ff;
	always_ff @(posedge clk_i) begin
		if (!rst_b_i || phase_ff >= per_i - 8'h01)
			phase_ff <= 8'h00;
		else
			phase_ff <= phase_ff + 8'h01;
	end
	assign pwm_demand_o = phase_ff < high_i;
	// an open low-side switch carries no sensed current
	assign ls_current_o = gate_i.ls_on ? cur_lvl_i : 8'h00;
endmodule // power_stage_model

// ===== tb/buck_seq_chk_sva.sv
/* assertions on the sequencer outputs
   assumes it is bound to the sequencer top, one clock domain */
`timescale 1ns/1ps
module buck_seq_chk #(
	parameter int HICCUP_LEN = 300
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// observed ports
	input wire buck_seq_pkg::supervise_type sup_i,
	input wire buck_seq_pkg::gate_type gate_o,
	input wire logic [20:0] ss_ref_uv_o,
	input wire logic overcurrent_flag_o,
	input wire logic startup_done_o
);
	import buck_seq_pkg::*;
	int oc_cnt;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	// cycles the flag has been held
	always_ff @(posedge clk_i) begin
		if (!rst_b_i || !overcurrent_flag_o)
			oc_cnt <= 0;
		else
			oc_cnt <= oc_cnt + 1;
	end
	////////////////////////////////////////
	a_enable_off: assert property (!sup_i.en_ok [*3] |-> gate_o == '0) // off
		else $error("gates on while disabled");
	a_thermal_off: assert property ( // off
		sup_i.thermal_trip [*3] |-> gate_o == '0 && ss_ref_uv_o == '0)
		else $error("gates on during thermal trip");
	a_ovp_blank: assert property (sup_i.overvoltage_protection [*2] |-> gate_o == '0) // blank
		else $error("gates on during overvoltage");
	a_no_por_idle: assert property ( // idle
		!sup_i.vcc_ok [*3] |-> !startup_done_o && ss_ref_uv_o == '0)
		else $error("sequence running without supply");
	a_ref_rises: assert property ( // ramp
		$changed(ss_ref_uv_o) && ss_ref_uv_o != '0
		|-> ss_ref_uv_o > $past(ss_ref_uv_o) && ss_ref_uv_o <= SS_FINAL_UV)
		else $error("reference ramp not rising");
	a_hiccup_ref: assert property ( // hold
		$rose(overcurrent_flag_o) |-> ##2 (ss_ref_uv_o == '0 && gate_o == '0) [*8])
		else $error("reference not held in hiccup");
	a_hiccup_min: assert property ( // length
		$fell(overcurrent_flag_o) && sup_i.en_ok |-> oc_cnt >= HICCUP_LEN - 2)
		else $error("hiccup too short");
	a_hiccup_ends: assert property (oc_cnt <= HICCUP_LEN + 4) // retry
		else $error("hiccup too long");
	c_hiccup: cover property ($rose(overcurrent_flag_o));
	c_done: cover property ($rose(startup_done_o));
	c_low_side: cover property ($rose(gate_o.ls_on));
endmodule // buck_seq_chk
bind buck_startup_fault_sequencer buck_seq_chk #(.HICCUP_LEN(HICCUP_LEN)) u_buck_seq_chk (
	.clk_i(clk_i), .rst_b_i(rst_b_i), .sup_i(sup_i), .gate_o(gate_o),
	.ss_ref_uv_o(ss_ref_uv_o), .overcurrent_flag_o(overcurrent_flag_o),
	.startup_done_o(startup_done_o));

// ===== tb/tb_top.sv
/* self-checking bench for the buck startup and fault sequencer
   assumes the power stage model and shortened start and hiccup counts */
`timescale 1ns/1ps
module tb_top;
	import buck_seq_pkg::*;
	localparam logic [7:0] LIM_F = 8'hc0;
	localparam logic [7:0] LIM_V = 8'he0;
	localparam logic [7:0] LIM_G = 8'h90;
	logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, sync = 0, sync_on = 0;
	logic pready, pslverr, demand, oc_flag, done, err, seen_hs = 0;
	logic [7:0] paddr = 8'h00, per = 8'h1a, lvl = 8'h00, cur;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0] fsel = 4'hc;
	logic [20:0] ss_ref;
	supervise_type sup = 4'hc;
	strap_type strap = STRAP_FLOAT;
	gate_type gate;
	int error_cnt = 0, comparisons = 0, w = 0, sc = 0, wq[$];
	always #12.5 clk = ~clk;
	buck_startup_fault_sequencer #(.START_CYCLES(200), .HICCUP_LEN(300), .LIMIT_FLOAT(LIM_F),
		.LIMIT_VCC(LIM_V), .LIMIT_POWER_GROUND(LIM_G)) u_buck_startup_fault_sequencer (
		.clk_i(clk), .rst_b_i(rst_b), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready), .prdata_o(prdata),
		.pslverr_o(pslverr), .sup_i(sup), .current_limit_select_pin_i(strap), .freq_sel_i(fsel),
		.freq_set_and_sync_pin_i(sync), .pwm_demand_i(demand), .ls_current_i(cur),
		.gate_o(gate), .ss_ref_uv_o(ss_ref), .overcurrent_flag_o(oc_flag), .startup_done_o(done));
	power_stage_model u_power_stage_model (.clk_i(clk), .rst_b_i(rst_b), .per_i(per),
		.high_i(8'h08), .cur_lvl_i(lvl), .gate_i(gate), .pwm_demand_o(demand), .ls_current_o(cur));
	// external sync clock of 60 cycles, low when removed
	always @(posedge clk) begin
		sc <= (sc == 59) ? 0 : sc + 1;
		sync <= sync_on && sc < 30;
	end
	// low-side pulse widths and first high-side pulse
	always @(posedge clk) begin
		if (!rst_b || !sup.en_ok || sup.thermal_trip || oc_flag)
			seen_hs <= 0;
		else if (gate.hs_on)
			seen_hs <= 1;
		if (gate.ls_on)
			w <= w + 1;
		else if (w != 0) begin
			wq.push_back(w);
			w <= 0;
		end
		if (gate.ls_on && !seen_hs && rst_b)
			fail("low side before high side"); // order
	end
	////////////////////////////////////////
	task automatic fail(input string m);
		error_cnt++;
		$display("unexpected %0t %s", $time, m);
	endtask
	task automatic chk(input logic [31:0] got, input int exp, input string m);
		comparisons++;
		if (got !== 32'(exp))
			fail(m);
	endtask
	task automatic chk_rng(input logic [31:0] got, input int lo, input int hi, input string m);
		comparisons++;
		if ((got >= lo && got <= hi) !== 1'b1)
			fail(m);
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic rd_period(input int n);
		repeat (n) @(posedge clk);
		apb(1'h0, PERIOD_OFS, 32'h0);
	endtask
	task automatic do_reset(input strap_type s, input logic [3:0] f);
		@(posedge clk);
		rst_b <= 0;
		strap <= s;
		fsel <= f;
		repeat (5) @(posedge clk);
		rst_b <= 1;
	endtask
	task automatic wait_oc(input logic v, input int lim);
		int n = 0;
		while (oc_flag !== v && n < lim) begin
			@(posedge clk);
			n++;
		end
	endtask
	task automatic end_of_test();
		if (error_cnt == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	////////////////////////////////////////
	task automatic t_regs();
		int f[3] = '{0, 5, 12};
		foreach (f[i]) begin
			do_reset(STRAP_FLOAT, 4'(f[i]));
			rd_period(0);
			chk(rd[15:0], 257 * (40000 / (300 + 100 * f[i])), "period"); // table
		end
		apb(1'h0, CTRL_OFS, 32'h0);
		chk(rd, CTRL_RST, "control reset value");
		apb(1'h1, 8'h40, 32'h5);
		chk(err, 1, "unmapped address error");
		chk(rd, 0, "unmapped address data");
	endtask
	task automatic t_prebias();
		int n = 0;
		int td = 0;
		logic [20:0] r0;
		do_reset(STRAP_FLOAT, 4'hc);
		sup.vcc_ok <= 0;
		repeat (50) @(posedge clk);
		chk({gate, done, ss_ref}, 0, "active without supply"); // gated
		while (demand !== 1'b1)
			@(posedge clk);
		while (demand !== 1'b0)
			@(posedge clk);
		sup.vcc_ok <= 1;
		wq.delete();
		while (wq.size() < 140 && n < 6000) begin
			@(posedge clk);
			n++;
			if (done === 1'b1 && td == 0)
				td = n;
		end
		chk_rng(td, 200, 204, "startup time"); // fixed
		for (int k = 1; k < 6; k++)
			chk(wq[16 * k - 16], 26 * k / 8, "step width"); // eighths
		chk(wq[15], 3, "pulses per step"); // sixteen
		chk_rng(wq[135], 17, 18, "steady low side"); // final
		r0 = ss_ref;
		repeat (1040) @(posedge clk);
		chk_rng(ss_ref - r0, 10140, 10660, "ramp slope"); // slope
	endtask
	task automatic t_oc();
		strap_type s[3] = '{STRAP_FLOAT, STRAP_VCC, STRAP_POWER_GROUND};
		logic [7:0] l[3] = '{LIM_F, LIM_V, LIM_G};
		foreach (s[i]) begin
			lvl <= 8'h00;
			do_reset(s[i], 4'hc);
			repeat (3600) @(posedge clk);
			lvl <= l[i];
			repeat (400) @(posedge clk);
			chk(oc_flag, 0, "flag at limit"); // strap
			lvl <= l[i] + 8'h01;
			wait_oc(1, 400);
			chk(oc_flag, 1, "flag over limit"); // trip
		end
		repeat (5) @(posedge clk);
		chk(ss_ref, 0, "reference held"); // hiccup
		apb(1'h0, STATUS_OFS, 32'h0);
		chk(rd[3:0], 4'hb, "status in hiccup"); // latched
		wait_oc(0, 400);
		wait_oc(1, 4000);
		chk(oc_flag, 1, "hiccup repeats"); // retry
		lvl <= 8'h00;
		wait_oc(0, 400);
		repeat (400) @(posedge clk);
		chk_rng({oc_flag, ss_ref}, 1, 1500000, "recovery"); // restart
	endtask
	task automatic t_off(input int k);
		case (k)
			0: sup.en_ok <= 0;
			1: sup.thermal_trip <= 1;
			2: apb(1'h1, CTRL_OFS, 32'h0);
			default: sup.overvoltage_protection <= 1;
		endcase
		repeat (4) @(posedge clk);
		chk(gate, 0, "gates off"); // drivers off
		if (k < 3)
			chk(ss_ref, 0, "ramp cleared"); // cleared
		sup <= 4'hc;
		if (k == 2)
			apb(1'h1, CTRL_OFS, 32'h1);
		repeat (400) @(posedge clk);
		chk_rng(ss_ref, 1, 1500000, "restarted"); // restart
		apb(1'h0, SSREF_OFS, 32'h0);
		chk_rng(rd, 1, 1500000, "reference register"); // ramp
	endtask
	task automatic t_sync();
		sync_on <= 1;
		per <= 8'h3c;
		rd_period(300);
		chk_rng(rd[15:0], 15387, 15419, "gradual to sync"); // gradual
		rd_period(4000);
		chk(rd[15:0], 15420, "locked to sync"); // reached
		sync_on <= 0;
		per <= 8'h1a;
		rd_period(600);
		chk_rng(rd[7:0], 27, 59, "gradual back"); // gradual
		rd_period(4000);
		chk(rd[15:0], 6682, "free running again"); // reached
	endtask
	initial begin
		t_regs();
		t_prebias();
		t_oc();
		for (int k = 0; k < 4; k++)
			t_off(k);
		t_sync();
		end_of_test();
	end
	initial begin
		repeat (60000) @(posedge clk);
		fail("timeout");
		end_of_test();
	end
endmodule // tb_top
